// File: rtl/vptd_phase_trim.v
// Functional notes
// - Voltage samples are shifted in time; current samples get no relative shift.
// - Shift equals trim value minus 0x0D, times eight master-clock periods.
// - Positive difference delays voltage samples; negative difference advances them.
// - Trim value 0x0D gives zero relative shift between the channels.
// - Trim value is read as a signed two's complement number.
// - Trim range covers 1.80 degree leads and 0.72 degree lags at 50 Hz.
// - Applied correction has the opposite sign to the phase error cancelled.
`timescale 1ns/1ps
`default_nettype none
`include "vptd_map.vh"

module vptd_phase_trim (
    // Clock and reset
    input  wire                           mclk_i,
    input  wire                           rst_b_i,
    // Sample stream from the converters, same clock domain
    input  wire [`VPTD_SAMPLE_W-1:0]      volt_sample_i,
    input  wire [`VPTD_SAMPLE_W-1:0]      curr_sample_i,
    input  wire                           sample_valid_i,
    // Calibration setting, same clock domain
    input  wire [`VPTD_TRIM_W-1:0]        phase_trim_value_i,
    // Aligned samples
    output reg  [`VPTD_SAMPLE_W-1:0]      volt_aligned_o,
    output reg  [`VPTD_SAMPLE_W-1:0]      curr_aligned_o,
    output reg                            aligned_valid_o,
    // Instantaneous power of the aligned pair
    output reg  [`VPTD_POWER_W-1:0]       inst_power_o,
    output reg                            power_valid_o,
    // Applied relative voltage shift in clock cycles, signed
    output reg  [`VPTD_SHIFT_W-1:0]       shift_cycles_o
);

    // Timing from the clock edge that takes a strobe (c0):
    //   c0    trim, held voltage and registered current are loaded
    //   c1    shift and voltage tap follow the new trim
    //   c2    reported shift follows
    //   c369  both delay lines present the words for c0
    //   c370  aligned pair and its strobe
    //   c371  product and its strobe
    // Both channels ride a common base delay, so the voltage tap can sit
    // before the current tap (an advance) as well as after it (a delay).
    // Limitation: for an advance the voltage seen is the newest sample at
    // most |shift| clocks after c0, so samples must be spaced
    // no wider than the advance to give a genuine sample rather than a repeat.

    // Signed shift in cycles for a trim code
    function [`VPTD_SHIFT_W-1:0] trim_to_shift;
        input [`VPTD_TRIM_W-1:0] trim;
        reg   [`VPTD_SHIFT_W-1:0] diff;
        reg   [31:0]              scaled;
        begin
            // Sign extend the code and zero extend the neutral value before subtracting
            diff = {{(`VPTD_SHIFT_W-`VPTD_TRIM_W){trim[`VPTD_TRIM_W-1]}}, trim}
                 - {{(`VPTD_SHIFT_W-`VPTD_TRIM_W){1'b0}}, `VPTD_TRIM_NEUTRAL};
            // Scale by the step in clocks; keeping the low bits is exact in
            // two's complement because the full range fits the shift width
            scaled = {{(32-`VPTD_SHIFT_W){diff[`VPTD_SHIFT_W-1]}}, diff} * `VPTD_STEP_CYCLES;
            trim_to_shift = scaled[`VPTD_SHIFT_W-1:0];
        end
    endfunction

    // Voltage tap from base plus signed shift, cut to the address width
    function [`VPTD_DL_AW-1:0] shift_to_tap;
        input [`VPTD_SHIFT_W-1:0] shift;
        reg   [`VPTD_SHIFT_W-1:0] sum;
        begin
            sum = {1'b0, `VPTD_BASE_CYCLES} + shift;
            shift_to_tap = sum[`VPTD_DL_AW-1:0];
        end
    endfunction

    reg  [`VPTD_TRIM_W-1:0]    trim_reg;
    reg  [`VPTD_SHIFT_W-1:0]   shift_reg;
    reg  [`VPTD_DL_AW-1:0]     volt_tap_reg;
    reg  [`VPTD_SAMPLE_W-1:0]  volt_hold_reg;
    wire [`VPTD_SAMPLE_W-1:0]  volt_del;
    wire [`VPTD_SAMPLE_W:0]    curr_del;
    wire [`VPTD_DL_AW-1:0]     curr_tap;
    wire signed [`VPTD_SAMPLE_W-1:0] volt_s;
    wire signed [`VPTD_SAMPLE_W-1:0] curr_s;
    wire signed [`VPTD_POWER_W-1:0]  product;

    // Current channel runs at the fixed base tap only
    assign curr_tap = `VPTD_BASE_CYCLES;

    // Trim is taken only at a sample boundary, so a new setting never
    // moves the tap halfway between two current samples.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trim_reg <= `VPTD_TRIM_RESET;
        end else if (sample_valid_i) begin
            trim_reg <= phase_trim_value_i;
        end
    end

    // Shift and voltage tap, registered to keep the adder off the RAM path.
    // With a 6-bit code the advance reaches 360 cycles and the delay 144,
    // which spans the required lead and lag range at 50 Hz.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_reg    <= {`VPTD_SHIFT_W{1'b0}};
            volt_tap_reg <= `VPTD_BASE_CYCLES;
        end else begin
            shift_reg    <= trim_to_shift(trim_reg);
            // Longer voltage tap is a delay, shorter is an advance
            volt_tap_reg <= shift_to_tap(trim_to_shift(trim_reg));
        end
    end

    // Voltage held between samples so the tap can land at any clock
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            volt_hold_reg <= {`VPTD_SAMPLE_W{1'b0}};
        end else if (sample_valid_i) begin
            volt_hold_reg <= volt_sample_i;
        end
    end

    // Voltage delay line, tap moves with the trim
    // Over the whole trim range the tap stays within 8 to 512 words of a
    // 1024-word line, so the read never overtakes the write.
    vptd_delay_line #(
        .WIDTH (`VPTD_SAMPLE_W),
        .AW    (`VPTD_DL_AW)
    ) u_volt_dl (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .data_i  (volt_hold_reg),
        .delay_i (volt_tap_reg),
        .data_o  (volt_del)
    );

    // Current delay line carries the strobe along with the sample.
    // The sample is registered here to match the hold stage on voltage.
    reg [`VPTD_SAMPLE_W:0] curr_in_reg;
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            curr_in_reg <= {(`VPTD_SAMPLE_W+1){1'b0}};
        end else begin
            curr_in_reg <= {sample_valid_i, curr_sample_i};
        end
    end

    vptd_delay_line #(
        .WIDTH (`VPTD_SAMPLE_W + 1),
        .AW    (`VPTD_DL_AW)
    ) u_curr_dl (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .data_i  (curr_in_reg),
        .delay_i (curr_tap),
        .data_o  (curr_del)
    );

    // Strobes that emerge during the first base-delay after reset would
    // read unwritten RAM; a fill counter suppresses them.
    // It spans the full RAM depth, so words left over from before a
    // reset in mid-run are overwritten before any strobe is reported.
    reg [`VPTD_DL_AW:0] fill_reg;
    wire                primed;
    assign primed = fill_reg[`VPTD_DL_AW];

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill_reg <= {(`VPTD_DL_AW+1){1'b0}};
        end else if (!primed) begin
            fill_reg <= fill_reg + {{`VPTD_DL_AW{1'b0}}, 1'b1};
        end
    end

    // Aligned pair, stands until the next strobe
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            volt_aligned_o  <= {`VPTD_SAMPLE_W{1'b0}};
            curr_aligned_o  <= {`VPTD_SAMPLE_W{1'b0}};
            aligned_valid_o <= 1'b0;
        end else begin
            aligned_valid_o <= curr_del[`VPTD_SAMPLE_W] & primed;
            if (curr_del[`VPTD_SAMPLE_W] & primed) begin
                // Equal taps at neutral trim give identical timing
                volt_aligned_o <= volt_del;
                curr_aligned_o <= curr_del[`VPTD_SAMPLE_W-1:0];
            end
        end
    end

    // Multiply only the shifted pair so power sees the corrected phase.
    // A later voltage tap turns a lagging current error back, which is
    // why the correction sign is opposite to the error.
    assign volt_s  = volt_aligned_o;
    assign curr_s  = curr_aligned_o;
    assign product = volt_s * curr_s;

    // Product registered one clock behind the pair it came from; both
    // operands are signed, so the full 32-bit result is exact
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            inst_power_o  <= {`VPTD_POWER_W{1'b0}};
            power_valid_o <= 1'b0;
        end else begin
            power_valid_o <= aligned_valid_o;
            if (aligned_valid_o) begin
                inst_power_o <= product;
            end
        end
    end

    // Report the shift in use, two clocks behind the trim register,
    // so software can read back what the voltage tap is applying
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_cycles_o <= {`VPTD_SHIFT_W{1'b0}};
        end else begin
            shift_cycles_o <= shift_reg;
        end
    end

endmodule // vptd_phase_trim

`default_nettype wire

// File: rtl/vptd_map.vh
`ifndef VPTD_MAP_VH
`define VPTD_MAP_VH

// Sample word width of both channels
`define VPTD_SAMPLE_W      16
// Width of the instantaneous power product
`define VPTD_POWER_W       32
// Width of the signed phase trim value
`define VPTD_TRIM_W        6
// Trim value that applies no shift
`define VPTD_TRIM_NEUTRAL  6'h0D
// Reset value of the trim, neutral so a fresh part is unshifted
`define VPTD_TRIM_RESET    6'h0D
// One trim step in master-clock periods
`define VPTD_STEP_CYCLES   8
// Width of a signed shift count in cycles
`define VPTD_SHIFT_W       11
// Address width of each delay line, depth is two to this power
`define VPTD_DL_AW         10
// Common delay both channels carry, so that an advance is possible.
// The most negative trim gives (-32 - 13) * 8 = -360 cycles, so a base
// of 368 keeps the voltage tap at 8 cycles or more.
`define VPTD_BASE_CYCLES   10'h170

`endif

// File: rtl/vptd_delay_line.v
`timescale 1ns/1ps
`default_nettype none

// Programmable delay line: a word written every clock comes back
// delay_i clocks later. delay_i must be at least 1.
module vptd_delay_line #(
    parameter WIDTH = 16,
    parameter AW    = 10
) (
    // Clock and reset
    input  wire             mclk_i,
    input  wire             rst_b_i,
    // Data and tap
    input  wire [WIDTH-1:0] data_i,
    input  wire [AW-1:0]    delay_i,
    output reg  [WIDTH-1:0] data_o
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];
    reg [AW-1:0]    wr_ptr_reg;
    wire [AW-1:0]   rd_ptr;

    // Read point trails the write point by the tap distance
    assign rd_ptr = wr_ptr_reg - delay_i;

    // Storage has no reset; stale words are masked by the fill counter upstream
    always @(posedge mclk_i) begin
        mem[wr_ptr_reg] <= data_i;
    end

    // Write pointer and registered read port
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            data_o     <= {WIDTH{1'b0}};
        end else begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            data_o     <= mem[rd_ptr];
        end
    end

endmodule // vptd_delay_line

`default_nettype wire

// File: dv/vptd_phase_trim_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the trim stage
module vptd_chk (
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    // Inputs
    input wire logic [15:0] volt_sample_i,
    input wire logic [15:0] curr_sample_i,
    input wire logic        sample_valid_i,
    input wire logic [5:0]  phase_trim_value_i,
    // Outputs
    input wire logic [15:0] volt_aligned_o,
    input wire logic [15:0] curr_aligned_o,
    input wire logic        aligned_valid_o,
    input wire logic [31:0] inst_power_o,
    input wire logic        power_valid_o,
    input wire logic [10:0] shift_cycles_o
);
    logic [10:0] up_reg;

    // Cycles since reset; strobes in the fill phase are not reported
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            up_reg <= 11'h000;
        else if (up_reg != 11'h7FF)
            up_reg <= up_reg + 11'h001;
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    shift_map_a: assert property (
        sample_valid_i |-> ##3 $signed(shift_cycles_o) ==
        ($signed($past(phase_trim_value_i, 3)) - 13) * 8) else $error("shift wrong");
    neutral_a: assert property (
        sample_valid_i && phase_trim_value_i == 6'h0D |-> ##3 shift_cycles_o == 11'h000)
        else $error("neutral shift wrong");
    power_follow_a: assert property (
        aligned_valid_o |=> power_valid_o) else $error("power strobe missing");
    power_cause_a: assert property (
        power_valid_o |-> $past(aligned_valid_o)) else $error("stray power strobe");
    power_value_a: assert property (
        aligned_valid_o |=> $signed(inst_power_o) ==
        $signed($past(volt_aligned_o)) * $signed($past(curr_aligned_o))) else $error("product wrong");
    curr_path_a: assert property (
        aligned_valid_o |-> $past(sample_valid_i, 371) &&
        curr_aligned_o == $past(curr_sample_i, 371)) else $error("current path wrong");
    curr_valid_a: assert property (
        up_reg > 11'h5DC && $past(sample_valid_i, 371) |-> aligned_valid_o)
        else $error("aligned strobe missing");
    pair_hold_a: assert property (
        !aligned_valid_o |-> $stable(volt_aligned_o) && $stable(curr_aligned_o))
        else $error("pair changed");
    power_hold_a: assert property (
        !power_valid_o |-> $stable(inst_power_o)) else $error("product changed");

    // Main scenarios
    cover property (aligned_valid_o && $signed(shift_cycles_o) < 0);
    cover property (aligned_valid_o && $signed(shift_cycles_o) > 0);
    cover property (power_valid_o);
endmodule // vptd_chk

bind vptd_phase_trim vptd_chk u_vptd_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .volt_sample_i(volt_sample_i),
    .curr_sample_i(curr_sample_i), .sample_valid_i(sample_valid_i),
    .phase_trim_value_i(phase_trim_value_i), .volt_aligned_o(volt_aligned_o),
    .curr_aligned_o(curr_aligned_o), .aligned_valid_o(aligned_valid_o),
    .inst_power_o(inst_power_o), .power_valid_o(power_valid_o),
    .shift_cycles_o(shift_cycles_o));
`default_nettype wire

// File: dv/vptd_phase_trim_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vptd_phase_trim_tb_top;
    logic        mclk_i;
    logic        rst_b_i;
    logic [15:0] volt_sample_i;
    logic [15:0] curr_sample_i;
    logic        sample_valid_i;
    logic [5:0]  phase_trim_value_i;
    wire  [15:0] volt_aligned_o;
    wire  [15:0] curr_aligned_o;
    wire         aligned_valid_o;
    wire  [31:0] inst_power_o;
    wire         power_valid_o;
    wire  [10:0] shift_cycles_o;
    int          err_count;
    int          checks;

    vptd_phase_trim u_vptd_phase_trim (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .volt_sample_i(volt_sample_i),
        .curr_sample_i(curr_sample_i), .sample_valid_i(sample_valid_i),
        .phase_trim_value_i(phase_trim_value_i), .volt_aligned_o(volt_aligned_o),
        .curr_aligned_o(curr_aligned_o), .aligned_valid_o(aligned_valid_o),
        .inst_power_o(inst_power_o), .power_valid_o(power_valid_o),
        .shift_cycles_o(shift_cycles_o));

    // 125 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // One strobe; returns on the edge that takes it
    task automatic strobe(input logic [15:0] v, input logic [15:0] c, input logic [5:0] t);
        @(posedge mclk_i);
        volt_sample_i <= v;
        curr_sample_i <= c;
        phase_trim_value_i <= t;
        sample_valid_i <= 1'b1;
        @(posedge mclk_i);
        sample_valid_i <= 1'b0;
    endtask

    // Pair under test sits between two marker voltages, so the tap position shows
    task automatic trim_case(input logic [5:0] t);
        logic signed [10:0] d;
        logic [15:0]        c;
        logic [15:0]        v;
        logic signed [31:0] p;
        int                 k;
        d = 11'(($signed(t) - 13) * 8);
        c = 16'h8001 + {10'h000, t};
        k = (d < 0) ? 4 - d - 8 : 4;
        v = (d > 0) ? 16'h1234 : ((d == 0) ? 16'hA5C3 : 16'h7E01);
        p = $signed(v) * $signed(c);
        strobe(16'h1234, 16'h0100, t);
        tick(200);
        strobe(16'hA5C3, c, t);
        tick(k - 2);
        strobe(16'h7E01, 16'h0200, t);
        tick(370 - k);
        #1;
        check(32'(aligned_valid_o), 32'h1);
        check(32'(volt_aligned_o), 32'(v));
        check(32'(curr_aligned_o), 32'(c));
        check({21'h0, shift_cycles_o}, {21'h0, d});
        tick(1);
        #1;
        check(32'(power_valid_o), 32'h1);
        check(inst_power_o, p);
    endtask

    // Second reset mid-run clears every output, trim back to neutral
    task automatic reset_case();
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        tick(2);
        #1;
        check(inst_power_o | {volt_aligned_o, curr_aligned_o}, 32'h0);
        check({20'h0, shift_cycles_o, aligned_valid_o | power_valid_o}, 32'h0);
        tick(1);
        rst_b_i <= 1'b1;
        tick(1200);
        #1;
        check({21'h0, shift_cycles_o}, 32'h0);
    endtask

    // Main sequence: neutral, delays and advances to both ends of the range
    initial begin
        err_count = 0;
        checks = 0;
        rst_b_i = 1'b0;
        sample_valid_i = 1'b0;
        volt_sample_i = 16'h0000;
        curr_sample_i = 16'h0000;
        phase_trim_value_i = 6'h0D;
        tick(8);
        rst_b_i <= 1'b1;
        tick(1200);
        trim_case(6'h0D);
        trim_case(6'h0E);
        trim_case(6'h1F);
        trim_case(6'h0C);
        trim_case(6'h00);
        trim_case(6'h20);
        reset_case();
        trim_case(6'h0E);
        end_sim();
    end

    // Watchdog, about three times the expected run
    initial begin
        #(8 * 20000);
        err_count++;
        end_sim();
    end
endmodule // vptd_phase_trim_tb_top
`default_nettype wire
